// ### design/atk_cfg.svh
`ifndef ATK_CFG_SVH
`define ATK_CFG_SVH
// Widths of the data paths
`define ATK_BLOCK_W     128
`define ATK_PUB_W       64
`define ATK_TAG_W       32
`define ATK_LEN_W       8
// Largest legal input lengths in bits
`define ATK_SECRET_MAX  8'h80
`define ATK_PUB_MAX     8'h40
// Cipher timing and constants
`define ATK_ROUNDS      4'hA
`define ATK_RCON_INIT   8'h01
`define ATK_SBOX_AFFINE 8'h63
`define ATK_GF_POLY     8'h1B
`define ATK_FLIP_MASK   128'h00000000000000000000000000000001
`endif

// ### design/atk_pkg.sv
package atk_pkg;
    // Derivation mode selected with each request
    typedef enum logic
    {
        ATK_SESSION_KEY_MODE,
        ATK_TAG_AND_CIPHER_KEY_MODE
    } atk_mode_t;
endpackage

// ### design/atk_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "atk_cfg.svh"
interface atk_if
    import atk_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_i
);
    logic                    start;
    atk_mode_t               mode;
    logic [`ATK_BLOCK_W-1:0] secret_input;
    logic [`ATK_LEN_W-1:0]   secret_len;
    logic [`ATK_PUB_W-1:0]   first_public_input;
    logic [`ATK_LEN_W-1:0]   first_public_len;
    logic [`ATK_PUB_W-1:0]   second_public_input;
    logic [`ATK_LEN_W-1:0]   second_public_len;
    logic [`ATK_LEN_W-1:0]   cipher_key_len;
    logic                    busy;
    logic                    done;
    logic [`ATK_BLOCK_W-1:0] session_key;
    logic [`ATK_TAG_W-1:0]   auth_tag;
    logic [`ATK_BLOCK_W-1:0] cipher_key_out;

    modport engine
    (
        input  clock_i, rst_i, start, mode, secret_input, secret_len,
        input  first_public_input, first_public_len, second_public_input,
        input  second_public_len, cipher_key_len,
        output busy, done, session_key, auth_tag, cipher_key_out
    );
    modport requester
    (
        input  clock_i, rst_i, busy, done, session_key, auth_tag, cipher_key_out,
        output start, mode, secret_input, secret_len, first_public_input,
        output first_public_len, second_public_input, second_public_len, cipher_key_len
    );
endinterface
`default_nettype wire

// ### design/atk_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "atk_cfg.svh"
module atk_engine
    import atk_pkg::*;
(
    atk_if.engine bus
);
    typedef enum {ST_IDLE, ST_FIRST, ST_SECOND} atk_state_t;

    atk_state_t              state;
    atk_mode_t               mode_q;
    logic [`ATK_BLOCK_W-1:0] key_q;
    logic [`ATK_BLOCK_W-1:0] round_key;
    logic [`ATK_BLOCK_W-1:0] blk;
    logic [7:0]              rcon;
    logic [3:0]              round_cnt;
    logic [`ATK_LEN_W-1:0]   t_len_q;
    logic [`ATK_BLOCK_W-1:0] next_round_key;
    logic [`ATK_BLOCK_W-1:0] next_blk;
    logic [`ATK_BLOCK_W-1:0] padded_key;
    logic [`ATK_BLOCK_W-1:0] padded_text;
    logic [`ATK_BLOCK_W-1:0] mask_first;
    logic [`ATK_BLOCK_W-1:0] mask_second;
    logic                    last_round;

    // Keeps the leading len bits of a vector whose index 127 is the MSB
    function automatic logic [`ATK_BLOCK_W-1:0] lead_mask(input logic [`ATK_LEN_W-1:0] len);
        lead_mask = ~({`ATK_BLOCK_W{1'b1}} >> len);
    endfunction

    // Field multiply modulo the AES polynomial
    function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = 8'h00;
        x = a;
        for (int i = 0; i < 8; i++)
        begin
            if (b[i])
                p = p ^ x;
            x = {x[6:0], 1'b0} ^ (x[7] ? `ATK_GF_POLY : 8'h00);
        end
        gmul = p;
    endfunction

    // Substitution byte: inverse as x^254, then the affine map
    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [7:0] p;
        logic [7:0] r;
        p = x;
        r = 8'h01;
        for (int i = 0; i < 7; i++)
        begin
            p = gmul(p, p);
            r = gmul(r, p);
        end
        sbox = r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]}
             ^ {r[3:0], r[7:4]} ^ `ATK_SBOX_AFFINE;
    endfunction

    // One AES round; the last round skips the column mix
    function automatic logic [`ATK_BLOCK_W-1:0] aes_round(input logic [`ATK_BLOCK_W-1:0] s,
                                                          input logic [`ATK_BLOCK_W-1:0] rk,
                                                          input logic last);
        logic [7:0] b [16];
        logic [7:0] h [16];
        logic [`ATK_BLOCK_W-1:0] o;
        for (int i = 0; i < 16; i++)
            b[i] = s[127-8*i -: 8];
        for (int c = 0; c < 4; c++)
            for (int r = 0; r < 4; r++)
                h[r+4*c] = sbox(b[r+4*((c+r)%4)]);
        for (int c = 0; c < 4; c++)
        begin
            if (last)
                o[127-32*c -: 32] = {h[4*c], h[4*c+1], h[4*c+2], h[4*c+3]};
            else
                o[127-32*c -: 32] =
                {
                    gmul(h[4*c], 8'h02) ^ gmul(h[4*c+1], 8'h03) ^ h[4*c+2] ^ h[4*c+3],
                    h[4*c] ^ gmul(h[4*c+1], 8'h02) ^ gmul(h[4*c+2], 8'h03) ^ h[4*c+3],
                    h[4*c] ^ h[4*c+1] ^ gmul(h[4*c+2], 8'h02) ^ gmul(h[4*c+3], 8'h03),
                    gmul(h[4*c], 8'h03) ^ h[4*c+1] ^ h[4*c+2] ^ gmul(h[4*c+3], 8'h02)
                };
        end
        aes_round = o ^ rk;
    endfunction

    // Next AES-128 round key from the current one
    function automatic logic [`ATK_BLOCK_W-1:0] key_step(input logic [`ATK_BLOCK_W-1:0] k,
                                                         input logic [7:0] rc);
        logic [31:0] w0;
        logic [31:0] w1;
        logic [31:0] w2;
        logic [31:0] w3;
        logic [31:0] tw;
        w3 = k[31:0];
        tw = {sbox(w3[23:16]) ^ rc, sbox(w3[15:8]), sbox(w3[7:0]), sbox(w3[31:24])};
        w0 = k[127:96] ^ tw;
        w1 = k[95:64] ^ w0;
        w2 = k[63:32] ^ w1;
        key_step = {w0, w1, w2, w2 ^ w3};
    endfunction

    // Input padding shared by both modes
    always_comb
    begin
        mask_first  = lead_mask(bus.first_public_len);
        mask_second = lead_mask(bus.second_public_len);
        padded_key  = bus.secret_input & lead_mask(bus.secret_len);
        padded_text =
        {
            bus.first_public_input & mask_first[127:64],
            bus.second_public_input & mask_second[127:64]
        };
    end

    // Round datapath
    always_comb
    begin
        last_round = (round_cnt == `ATK_ROUNDS);
        next_round_key = key_step(round_key, rcon);
        next_blk = aes_round(blk, next_round_key, last_round);
    end

    // Sequencer: two chained encryptions per request
    always_ff @(posedge bus.clock_i or posedge bus.rst_i)
    begin
        if (bus.rst_i)
        begin
            state     <= ST_IDLE;
            mode_q    <= ATK_SESSION_KEY_MODE;
            key_q     <= '0;
            round_key <= '0;
            blk       <= '0;
            rcon      <= `ATK_RCON_INIT;
            round_cnt <= 4'h1;
            t_len_q   <= '0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                begin
                    if (bus.start)
                    begin
                        state     <= ST_FIRST;
                        mode_q    <= bus.mode;
                        key_q     <= padded_key;
                        round_key <= padded_key;
                        blk       <= padded_text ^ padded_key;
                        rcon      <= `ATK_RCON_INIT;
                        round_cnt <= 4'h1;
                        t_len_q   <= bus.cipher_key_len;
                    end
                end
                ST_FIRST, ST_SECOND:
                begin
                    if (!last_round)
                    begin
                        round_key <= next_round_key;
                        blk       <= next_blk;
                        rcon      <= gmul(rcon, 8'h02);
                        round_cnt <= round_cnt + 4'h1;
                    end
                    else if (state == ST_FIRST)
                    begin
                        // Second pass restarts from the same padded key
                        state     <= ST_SECOND;
                        round_key <= key_q;
                        rcon      <= `ATK_RCON_INIT;
                        round_cnt <= 4'h1;
                        if (mode_q == ATK_TAG_AND_CIPHER_KEY_MODE)
                            blk <= next_blk ^ `ATK_FLIP_MASK ^ key_q;
                        else
                            blk <= next_blk ^ key_q;
                    end
                    else
                    begin
                        state <= ST_IDLE;
                        blk   <= '0;
                    end
                end
            endcase
        end
    end

    // Result registers, held until the next request
    always_ff @(posedge bus.clock_i or posedge bus.rst_i)
    begin
        if (bus.rst_i)
        begin
            bus.session_key    <= '0;
            bus.auth_tag       <= '0;
            bus.cipher_key_out <= '0;
            bus.done           <= 1'b0;
            bus.busy           <= 1'b0;
        end
        else
        begin
            bus.done <= (state == ST_SECOND) && last_round;
            bus.busy <= (state == ST_IDLE) ? bus.start : !((state == ST_SECOND) && last_round);
            if ((state == ST_FIRST) && last_round)
            begin
                if (mode_q == ATK_TAG_AND_CIPHER_KEY_MODE)
                    bus.auth_tag <= next_blk[127:96];
                else
                    bus.auth_tag <= '0;
            end
            if ((state == ST_SECOND) && last_round)
            begin
                if (mode_q == ATK_SESSION_KEY_MODE)
                begin
                    bus.session_key    <= next_blk;
                    bus.cipher_key_out <= '0;
                end
                else
                begin
                    bus.session_key    <= '0;
                    bus.cipher_key_out <= next_blk & lead_mask(t_len_q);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### design/atk_requester.sv
`timescale 1ns/10ps
`default_nettype none
`include "atk_cfg.svh"
module atk_requester
    import atk_pkg::*;
(
    atk_if.requester                bus,
    input  wire logic               req_i,
    input  wire atk_mode_t          mode_i,
    input  wire logic [127:0]       secret_input_i,
    input  wire logic [7:0]         secret_len_i,
    input  wire logic [63:0]        first_public_input_i,
    input  wire logic [7:0]         first_public_len_i,
    input  wire logic [63:0]        second_public_input_i,
    input  wire logic [7:0]         second_public_len_i,
    input  wire logic [7:0]         cipher_key_len_i,
    output logic                    accepted_o,
    output logic                    done_o,
    output logic [127:0]            session_key_o,
    output logic [31:0]             auth_tag_o,
    output logic [127:0]            cipher_key_out_o
);
    logic pending;

    // Limits a requested length to its largest legal value
    function automatic logic [7:0] clamp_len(input logic [7:0] len, input logic [7:0] max_len);
        clamp_len = (len > max_len) ? max_len : len;
    endfunction

    // Launch: one start pulse per request, only while the engine is idle
    always_ff @(posedge bus.clock_i or posedge bus.rst_i)
    begin
        if (bus.rst_i)
        begin
            bus.start               <= 1'b0;
            bus.mode                <= ATK_SESSION_KEY_MODE;
            bus.secret_input        <= '0;
            bus.secret_len          <= '0;
            bus.first_public_input  <= '0;
            bus.first_public_len    <= '0;
            bus.second_public_input <= '0;
            bus.second_public_len   <= '0;
            bus.cipher_key_len      <= '0;
            pending                 <= 1'b0;
            accepted_o              <= 1'b0;
        end
        else
        begin
            bus.start  <= 1'b0;
            accepted_o <= 1'b0;
            if (req_i && !pending && !bus.busy && !bus.start)
            begin
                // Lengths clamped to their legal maxima
                bus.mode                <= mode_i;
                bus.secret_input        <= secret_input_i;
                bus.secret_len          <= clamp_len(secret_len_i, `ATK_SECRET_MAX);
                bus.first_public_input  <= first_public_input_i;
                bus.first_public_len    <= clamp_len(first_public_len_i, `ATK_PUB_MAX);
                bus.second_public_input <= second_public_input_i;
                bus.second_public_len   <= clamp_len(second_public_len_i, `ATK_PUB_MAX);
                bus.cipher_key_len      <= clamp_len(cipher_key_len_i, `ATK_SECRET_MAX);
                bus.start               <= 1'b1;
                pending                 <= 1'b1;
                accepted_o              <= 1'b1;
            end
            else if (bus.done)
                pending <= 1'b0;
        end
    end

    // Capture of results on completion
    always_ff @(posedge bus.clock_i or posedge bus.rst_i)
    begin
        if (bus.rst_i)
        begin
            done_o           <= 1'b0;
            session_key_o    <= '0;
            auth_tag_o       <= '0;
            cipher_key_out_o <= '0;
        end
        else
        begin
            done_o <= bus.done;
            if (bus.done)
            begin
                session_key_o    <= bus.session_key;
                auth_tag_o       <= bus.auth_tag;
                cipher_key_out_o <= bus.cipher_key_out;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/atk_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "atk_cfg.svh"
module atk_props
(
    input wire logic                    clock_i,
    input wire logic                    rst_i,
    input wire logic                    start,
    input wire logic                    busy,
    input wire logic                    done,
    input wire logic [`ATK_BLOCK_W-1:0] session_key,
    input wire logic [`ATK_TAG_W-1:0]   auth_tag,
    input wire logic [`ATK_BLOCK_W-1:0] cipher_key_out,
    input wire logic [`ATK_LEN_W-1:0]   cipher_key_len
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // Latency and handshake of one run
    AST_START_TO_DONE: assert property (start && !busy |-> ##21 done)
        else $error("done not 21 cycles after start");
    // Busy drops at the same edge that raises done
    AST_BUSY_AT_DONE: assert property (done |-> !busy && $past(busy))
        else $error("busy wrong around done");
    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done longer than one cycle");
    AST_START_PULSE: assert property (start |=> !start)
        else $error("start longer than one cycle");
    AST_START_IDLE: assert property (start |-> !busy)
        else $error("start while busy");
    // Session key and cipher key only move when a run completes
    AST_HOLD_OUTPUTS: assert property
        (!done |-> $stable(session_key) && $stable(cipher_key_out))
        else $error("results moved outside done");
    // Only one mode result is exposed
    AST_MODE_RESULTS: assert property
        (done |-> session_key == 0 || (auth_tag == 0 && cipher_key_out == 0))
        else $error("both mode results nonzero");
    // Cipher key bits at and beyond t stay zero
    AST_KEY_TAIL_ZERO: assert property
        (done |-> (cipher_key_out << cipher_key_len) == 128'h0)
        else $error("cipher key tail not zero");
endmodule
`default_nettype wire

// ### tb/aes_tag_and_key_derivation_tb.sv
`timescale 1ns/10ps
`default_nettype none
module aes_tag_and_key_derivation_tb
    import atk_pkg::*;
;
    logic         clock_i;
    logic         rst_i;
    logic         req_i;
    atk_mode_t    mode_i;
    logic [127:0] secret_input_i;
    logic [7:0]   secret_len_i;
    logic [63:0]  first_public_input_i;
    logic [7:0]   first_public_len_i;
    logic [63:0]  second_public_input_i;
    logic [7:0]   second_public_len_i;
    logic [7:0]   cipher_key_len_i;
    logic         accepted_o;
    logic         done_o;
    logic [127:0] session_key_o;
    logic [31:0]  auth_tag_o;
    logic [127:0] cipher_key_out_o;
    int           err_total;
    int           samples_checked;
    int           accept_count;
    int           test_no;

    atk_if atk_if_i (.clock_i(clock_i), .rst_i(rst_i));
    atk_engine atk_engine_i (.bus(atk_if_i));
    atk_requester atk_requester_i (.bus(atk_if_i), .req_i(req_i), .mode_i(mode_i),
        .secret_input_i(secret_input_i), .secret_len_i(secret_len_i),
        .first_public_input_i(first_public_input_i), .first_public_len_i(first_public_len_i),
        .second_public_input_i(second_public_input_i),
        .second_public_len_i(second_public_len_i), .cipher_key_len_i(cipher_key_len_i),
        .accepted_o(accepted_o), .done_o(done_o), .session_key_o(session_key_o),
        .auth_tag_o(auth_tag_o), .cipher_key_out_o(cipher_key_out_o));
    atk_props atk_props_i (.clock_i(atk_if_i.clock_i), .rst_i(atk_if_i.rst_i),
        .start(atk_if_i.start), .busy(atk_if_i.busy), .done(atk_if_i.done),
        .session_key(atk_if_i.session_key), .auth_tag(atk_if_i.auth_tag),
        .cipher_key_out(atk_if_i.cipher_key_out), .cipher_key_len(atk_if_i.cipher_key_len));

    // Free running clock
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    // Count launched requests
    always @(posedge clock_i)
        if (accepted_o === 1'b1) accept_count++;

    task automatic chk_block(input string what, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One request, then a stray request and changed inputs while it runs
    task automatic run(input atk_mode_t m, input logic [127:0] s, input logic [7:0] sl,
        input logic [63:0] a, input logic [7:0] al, input logic [63:0] b, input logic [7:0] bl,
        input logic [7:0] t, input logic [127:0] es, input logic [31:0] et,
        input logic [127:0] ec);
        int n;
        @(posedge clock_i);
        mode_i <= m;
        secret_input_i <= s;
        secret_len_i <= sl;
        first_public_input_i <= a;
        first_public_len_i <= al;
        second_public_input_i <= b;
        second_public_len_i <= bl;
        cipher_key_len_i <= t;
        req_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        while (accepted_o !== 1'b1 && n < 40);
        chk_word("accepted_o", 32'h1, {31'h0, accepted_o});
        @(posedge clock_i);
        secret_input_i <= ~s;
        first_public_input_i <= ~a;
        @(posedge clock_i);
        req_i <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        while (done_o !== 1'b1 && n < 40);
        test_no++;
        chk_word("done_o", 32'h1, {31'h0, done_o});
        chk_block("session_key", es, session_key_o);
        chk_word("auth_tag", et, auth_tag_o);
        chk_block("cipher_key_out", ec, cipher_key_out_o);
        $display("test %0d ended, mismatches %0d", test_no, err_total);
    endtask

    // Watchdog against a hung run
    initial
    begin
        repeat (2000) @(posedge clock_i);
        err_total++;
        stop_test();
    end

    initial
    begin
        err_total = 0;
        samples_checked = 0;
        accept_count = 0;
        test_no = 0;
        rst_i = 1'b1;
        req_i = 1'b0;
        mode_i = ATK_SESSION_KEY_MODE;
        secret_input_i = 128'h0;
        secret_len_i = 8'h00;
        first_public_input_i = 64'h0;
        first_public_len_i = 8'h00;
        second_public_input_i = 64'h0;
        second_public_len_i = 8'h00;
        cipher_key_len_i = 8'h00;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        run(ATK_SESSION_KEY_MODE, 128'h42025EE339743AF647B5778025E9B66D, 8'h80,
            64'hA0F3624E949640A0, 8'h40, 64'h17DA4751F5B2B180, 8'h40, 8'h80,
            128'h294016C034CD1A5576081826366A7E4A, 32'h0, 128'h0);
        run(ATK_SESSION_KEY_MODE, 128'hD080644999A0D8B73653FFFFFFFFFFFF, 8'h50,
            64'h89E394B277B6FFFF, 8'h30, 64'hD48E6D18F1C655EF, 8'h3C, 8'h80,
            128'h9F05E22ADBCF67D829DB6B1810B4BA50, 32'h0, 128'h0);
        run(ATK_SESSION_KEY_MODE, 128'hBCD32DB021D5D00993428051F1CC37AB, 8'h78,
            64'h10439453B0B8733C, 8'h3C, 64'hAFE2C12D7DC18F55, 8'h38, 8'h00,
            128'hCE6AAEDBE96CDCE78650116CDD109180, 32'h0, 128'h0);
        run(ATK_TAG_AND_CIPHER_KEY_MODE, 128'h42025EE339743AF647B5778025E9B66D, 8'h80,
            64'hA0F3624E949640A0, 8'h40, 64'h17DA4751F5B2B180, 8'h40, 8'h80,
            128'h0, 32'hFAA865E7, 128'h4D4853333C5641B723A6EF41112B83BA);
        run(ATK_TAG_AND_CIPHER_KEY_MODE, 128'h5DDB5285D9072931833B35567776898A, 8'h80,
            64'h8493A3292770FA99, 8'h40, 64'hB950D6D2E77E641D, 8'h40, 8'h50,
            128'h0, 32'h2F2863B4, 128'hCAEE95550F277C157E84000000000000);
        chk_word("accepted count", 32'h5, 32'(accept_count));
        stop_test();
    end
endmodule
`default_nettype wire
